// ===== hw/gate_driver_protection_config.v
`timescale 1ns/100ps
`include "gate_cfg_regs.vh"

// Overview of operation
// - single-bit failsafe: 0 pulls low, 1 none
// - shoot-through failsafe: low, high, reserved, none
// - serial failsafe resets to 2; 2,3 none
// - writing reserved bit 10 sets crc flag
// - odd bias select gated by odd enable
// - disable bits: 0 enables, 1 disables
// - enable bits: 1 enables the function
// - thermal and desaturation deglitch times per code
// - gate monitor blanking 500 to 4000 ns
// - bit 15 masks gate monitor during turnoff
// - desat threshold 2.5 V plus 0.5 V steps
// - clamp threshold 1.5, 2, 3, 4 V
// - turnoff mode: soft, two-level, fault coverage
// - mute bit ignores pwm after faults
// - overcurrent threshold 200 to 950 mV
// - short threshold 500 to 1250 mV
// - short and overcurrent blanking times per code
// - thermal threshold 1.00 to 2.75 V
// - secondary undervolt threshold points per code
// - adc alignment modes, sampling enable resets 1
// - adc sample delay 280 to 1120 ns
// - adc fault: low, high, hi-z, none
module gate_driver_protection_config (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire wr_en_i,
  input wire [4:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  input wire [4:0] rd_addr_i,
  input wire crc_flag_clr_i,
  input wire fault_primary_undervolt_i,
  input wire fault_primary_overvolt_i,
  input wire fault_pwm_check_i,
  input wire fault_shoot_through_i,
  input wire fault_serial_i,
  input wire fault_regulator_i,
  input wire fault_inter_die_comm_i,
  input wire fault_config_crc_i,
  input wire fault_converter_i,
  input wire turnoff_active_i,
  output reg [15:0] rd_data_o,
  output reg primary_config_crc_flag_o,
  output reg [1:0] gate_action_o,
  output reg [2:0] odd_bias_on_o,
  output reg even_input_source_enable_o,
  output reg secondary_undervolt_on_o,
  output reg secondary_overvolt_on_o,
  output reg gate_monitor_on_o,
  output reg miller_clamp_on_o,
  output reg short_protect_on_o,
  output reg overcurrent_protect_on_o,
  output reg collector_clamp_on_o,
  output reg saturation_detect_on_o,
  output reg switch_thermal_on_o,
  output reg negative_rail_lockout_on_o,
  output reg clamp_location_select_o,
  output reg [7:0] switch_thermal_filter_cycles_o,
  output reg [7:0] saturation_filter_cycles_o,
  output reg [7:0] gate_monitor_blank_cycles_o,
  output reg gate_monitor_active_o,
  output reg [3:0] saturation_threshold_o,
  output reg [1:0] clamp_threshold_o,
  output reg soft_turnoff_enable_o,
  output reg two_level_turnoff_enable_o,
  output reg [1:0] turnoff_coverage_o,
  output reg pwm_mute_enable_o,
  output reg [3:0] overcurrent_threshold_o,
  output reg [1:0] short_threshold_o,
  output reg [7:0] short_blank_cycles_o,
  output reg [7:0] overcurrent_blank_cycles_o,
  output reg [2:0] switch_thermal_threshold_o,
  output reg [1:0] secondary_undervolt_threshold_o,
  output reg converter_sample_enable_o,
  output reg [1:0] converter_sample_alignment_o,
  output reg [7:0] converter_sample_delay_cycles_o
);

  // counts round up so no interval is ever shorter than asked
  localparam integer ADC_DLY_INT = (`ADC_DLY_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer TSD_DGL_INT = (`TSD_DGL_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer DSAT_DGL_INT = (`DESAT_DGL_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer SHORT_BLANK_TIME_INT = (`SHORT_BLANK_TIME_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer OVERCURRENT_BLANK_TIME_INT = (`OVERCURRENT_BLANK_TIME_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer GM_INT_0 = (`GATE_MONITOR_BLANK_TIME_0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer GM_INT_1 = (`GATE_MONITOR_BLANK_TIME_1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer GM_INT_2 = (`GATE_MONITOR_BLANK_TIME_2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer GM_INT_3 = (`GATE_MONITOR_BLANK_TIME_3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0] ADC_DLY_CYC = ADC_DLY_INT[7:0];
  localparam [7:0] TSD_DGL_CYC = TSD_DGL_INT[7:0];
  localparam [7:0] DSAT_DGL_CYC = DSAT_DGL_INT[7:0];
  localparam [7:0] SHORT_BLANK_TIME_CYC = SHORT_BLANK_TIME_INT[7:0];
  localparam [7:0] OVERCURRENT_BLANK_TIME_CYC = OVERCURRENT_BLANK_TIME_INT[7:0];
  localparam [7:0] GM_CYC_0 = GM_INT_0[7:0];
  localparam [7:0] GM_CYC_1 = GM_INT_1[7:0];
  localparam [7:0] GM_CYC_2 = GM_INT_2[7:0];
  localparam [7:0] GM_CYC_3 = GM_INT_3[7:0];

  reg [15:0] failsafe_and_bias_config;
  reg [15:0] protection_enable_config;
  reg [15:0] saturation_turnoff_config;
  reg [15:0] current_thermal_threshold_config;
  reg [15:0] supply_lockout_adc_config;

  // one-bit failsafe: 0 means pull low
  function [1:0] single_action;
    input sel;
    begin
      single_action = sel ? `ACT_NONE : `ACT_LOW;
    end
  endfunction

  // one decoder for all strobes keeps the address map in one place
  function addr_hit;
    input en;
    input [4:0] addr;
    input [4:0] reg_addr;
    begin
      addr_hit = en && (addr == reg_addr);
    end
  endfunction

  // soft and two-level share one field; codes 0 and 4 turn both off
  function turnoff_on;
    input [2:0] code;
    input two_level;
    begin
      turnoff_on = (code[2] == two_level) && (code[1:0] != 2'h0);
    end
  endfunction

  wire wr_fs = addr_hit(wr_en_i, wr_addr_i, `ADDR_FAILSAFE_BIAS);
  wire wr_pe = addr_hit(wr_en_i, wr_addr_i, `ADDR_PROT_ENABLE);
  wire wr_st = addr_hit(wr_en_i, wr_addr_i, `ADDR_SAT_TURNOFF);
  wire wr_ct = addr_hit(wr_en_i, wr_addr_i, `ADDR_CUR_THERMAL);
  wire wr_la = addr_hit(wr_en_i, wr_addr_i, `ADDR_LOCKOUT_ADC);

  // writes are accepted in any state; gating to configuration state two is the host's duty
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      failsafe_and_bias_config <= `RST_FAILSAFE_BIAS;
      protection_enable_config <= `RST_PROT_ENABLE;
      saturation_turnoff_config <= `RST_SAT_TURNOFF;
      current_thermal_threshold_config <= `RST_CUR_THERMAL;
      supply_lockout_adc_config <= `RST_LOCKOUT_ADC;
    end else begin
      if (wr_fs) begin
        failsafe_and_bias_config <= wr_data_i;
      end
      if (wr_pe) begin
        protection_enable_config <= wr_data_i;
      end
      if (wr_st) begin
        saturation_turnoff_config <= wr_data_i;
      end
      if (wr_ct) begin
        current_thermal_threshold_config <= wr_data_i;
      end
      if (wr_la) begin
        supply_lockout_adc_config <= wr_data_i;
      end
    end
  end

  // set wins over clear so a reserved-bit write is never lost
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_config_crc_flag_o <= 1'b0;
    end else if (wr_fs && wr_data_i[`FS_RESERVED_BIT]) begin
      primary_config_crc_flag_o <= 1'b1;
    end else if (crc_flag_clr_i) begin
      primary_config_crc_flag_o <= 1'b0;
    end
  end

  // gate action: first active fault in fixed priority order wins
  reg [1:0] next_action;
  always @* begin
    next_action = `ACT_NONE;
    if (fault_primary_undervolt_i) begin
      next_action = single_action(failsafe_and_bias_config[15]);
    end else if (fault_primary_overvolt_i) begin
      next_action = single_action(failsafe_and_bias_config[14]);
    end else if (fault_pwm_check_i) begin
      next_action = single_action(failsafe_and_bias_config[13]);
    end else if (fault_shoot_through_i) begin
      case (failsafe_and_bias_config[12:11])
        2'h0: next_action = `ACT_LOW;
        2'h1: next_action = `ACT_HIGH;
        default: next_action = `ACT_NONE;
      endcase
    end else if (fault_serial_i) begin
      case (failsafe_and_bias_config[9:8])
        2'h0: next_action = `ACT_LOW;
        2'h1: next_action = `ACT_HIGH;
        default: next_action = `ACT_NONE;
      endcase
    end else if (fault_regulator_i) begin
      next_action = single_action(failsafe_and_bias_config[7]);
    end else if (fault_inter_die_comm_i) begin
      next_action = single_action(failsafe_and_bias_config[6]);
    end else if (fault_config_crc_i || primary_config_crc_flag_o) begin
      // a latched flag keeps the failsafe applied until software clears it
      next_action = single_action(failsafe_and_bias_config[3]);
    end else if (fault_converter_i) begin
      next_action = supply_lockout_adc_config[1:0];
    end
  end

  // blanking code to cycles; used for gate monitor only, table is non-linear
  function [7:0] gm_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0: gm_cycles = GM_CYC_0;
        2'h1: gm_cycles = GM_CYC_1;
        2'h2: gm_cycles = GM_CYC_2;
        default: gm_cycles = GM_CYC_3;
      endcase
    end
  endfunction

  reg [7:0] next_oc_blank;
  always @* begin
    case (current_thermal_threshold_config[5:3])
      3'h6: next_oc_blank = 8'd10 * OVERCURRENT_BLANK_TIME_CYC;
      3'h7: next_oc_blank = 8'd20 * OVERCURRENT_BLANK_TIME_CYC;
      default: next_oc_blank = ({5'h00, current_thermal_threshold_config[5:3]} + 8'h01) * OVERCURRENT_BLANK_TIME_CYC;
    endcase
  end

  wire [2:0] mode = saturation_turnoff_config[`TURNOFF_MSB:`TURNOFF_LSB];

  // read data is registered, so it follows the address by one cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      case (rd_addr_i)
        `ADDR_FAILSAFE_BIAS: rd_data_o <= failsafe_and_bias_config;
        `ADDR_PROT_ENABLE: rd_data_o <= protection_enable_config;
        `ADDR_SAT_TURNOFF: rd_data_o <= saturation_turnoff_config;
        `ADDR_CUR_THERMAL: rd_data_o <= current_thermal_threshold_config;
        `ADDR_LOCKOUT_ADC: rd_data_o <= supply_lockout_adc_config;
        default: rd_data_o <= 16'h0000;
      endcase
    end
  end

  // registered action costs a cycle of fault reaction but avoids glitches
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_action_o <= `ACT_NONE;
    end else begin
      gate_action_o <= next_action;
    end
  end

  // bias current only flows with the odd source on
  genvar b;
  generate
    for (b = 0; b < 3; b = b + 1) begin : g_odd_bias
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          odd_bias_on_o[b] <= 1'b0;
        end else begin
          odd_bias_on_o[b] <= failsafe_and_bias_config[5] && failsafe_and_bias_config[b];
        end
      end
    end
  endgenerate

  // disable bits are inverted so every _on output reads 1 when enabled
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      even_input_source_enable_o <= 1'b0;
      secondary_undervolt_on_o <= 1'b0;
      secondary_overvolt_on_o <= 1'b0;
      gate_monitor_on_o <= 1'b0;
      miller_clamp_on_o <= 1'b0;
      short_protect_on_o <= 1'b0;
      overcurrent_protect_on_o <= 1'b0;
      collector_clamp_on_o <= 1'b0;
      saturation_detect_on_o <= 1'b0;
      switch_thermal_on_o <= 1'b0;
      negative_rail_lockout_on_o <= 1'b0;
      clamp_location_select_o <= 1'b0;
    end else begin
      even_input_source_enable_o <= failsafe_and_bias_config[4];
      secondary_undervolt_on_o <= ~protection_enable_config[15];
      secondary_overvolt_on_o <= ~protection_enable_config[11];
      gate_monitor_on_o <= ~protection_enable_config[7];
      miller_clamp_on_o <= ~protection_enable_config[6];
      short_protect_on_o <= ~protection_enable_config[3];
      overcurrent_protect_on_o <= ~protection_enable_config[2];
      collector_clamp_on_o <= protection_enable_config[5];
      saturation_detect_on_o <= protection_enable_config[4];
      switch_thermal_on_o <= protection_enable_config[1];
      negative_rail_lockout_on_o <= protection_enable_config[0];
      clamp_location_select_o <= protection_enable_config[10];
    end
  end

  // all timings fit in eight bits at this clock; a faster clock needs wider counts
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switch_thermal_filter_cycles_o <= 8'h00;
      saturation_filter_cycles_o <= 8'h00;
      gate_monitor_blank_cycles_o <= 8'h00;
      short_blank_cycles_o <= 8'h00;
      overcurrent_blank_cycles_o <= 8'h00;
    end else begin
      switch_thermal_filter_cycles_o <= ({6'h00, protection_enable_config[14:13]} + 8'h01) * TSD_DGL_CYC;
      saturation_filter_cycles_o <= protection_enable_config[12] ? 8'd2 * DSAT_DGL_CYC : DSAT_DGL_CYC;
      gate_monitor_blank_cycles_o <= gm_cycles(protection_enable_config[9:8]);
      short_blank_cycles_o <= SHORT_BLANK_TIME_CYC << current_thermal_threshold_config[7:6];
      overcurrent_blank_cycles_o <= next_oc_blank;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_monitor_active_o <= 1'b0;
      soft_turnoff_enable_o <= 1'b0;
      two_level_turnoff_enable_o <= 1'b0;
      turnoff_coverage_o <= 2'h0;
      pwm_mute_enable_o <= 1'b0;
    end else begin
      // monitor stays active in turnoff unless masked
      gate_monitor_active_o <= ~protection_enable_config[7] &&
        !(saturation_turnoff_config[15] && turnoff_active_i);
      soft_turnoff_enable_o <= turnoff_on(mode, 1'b0);
      two_level_turnoff_enable_o <= turnoff_on(mode, 1'b1);
      turnoff_coverage_o <= mode[1:0];
      pwm_mute_enable_o <= saturation_turnoff_config[0];
    end
  end

  // thresholds leave as raw codes; the analog side owns the voltage tables
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      saturation_threshold_o <= 4'h0;
      clamp_threshold_o <= 2'h0;
      overcurrent_threshold_o <= 4'h0;
      short_threshold_o <= 2'h0;
      switch_thermal_threshold_o <= 3'h0;
      secondary_undervolt_threshold_o <= 2'h0;
    end else begin
      saturation_threshold_o <= saturation_turnoff_config[14:11];
      clamp_threshold_o <= saturation_turnoff_config[7:6];
      overcurrent_threshold_o <= current_thermal_threshold_config[15:12];
      short_threshold_o <= current_thermal_threshold_config[11:10];
      switch_thermal_threshold_o <= current_thermal_threshold_config[2:0];
      secondary_undervolt_threshold_o <= supply_lockout_adc_config[15:14];
    end
  end

  // reserved alignment code 3 is passed on as written
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_sample_enable_o <= 1'b0;
      converter_sample_alignment_o <= 2'h0;
      converter_sample_delay_cycles_o <= 8'h00;
    end else begin
      converter_sample_enable_o <= supply_lockout_adc_config[7];
      converter_sample_alignment_o <= supply_lockout_adc_config[6:5];
      converter_sample_delay_cycles_o <= ({6'h00, supply_lockout_adc_config[4:3]} + 8'h01) * ADC_DLY_CYC;
    end
  end

endmodule // gate_driver_protection_config

// ===== inc/gate_cfg_regs.vh
`ifndef GATE_CFG_REGS_VH
`define GATE_CFG_REGS_VH

// register addresses on the serial control port
`define ADDR_FAILSAFE_BIAS 5'h02
`define ADDR_PROT_ENABLE 5'h03
`define ADDR_SAT_TURNOFF 5'h04
`define ADDR_CUR_THERMAL 5'h05
`define ADDR_LOCKOUT_ADC 5'h06

// reset values
`define RST_FAILSAFE_BIAS 16'h0200
`define RST_PROT_ENABLE 16'h0934
`define RST_SAT_TURNOFF 16'h7741
`define RST_CUR_THERMAL 16'h0902
`define RST_LOCKOUT_ADC 16'haa90

// field positions
`define FS_RESERVED_BIT 10
`define TURNOFF_LSB 1
`define TURNOFF_MSB 3

// gate action codes presented to the output stage
`define ACT_LOW 2'h0
`define ACT_HIGH 2'h1
`define ACT_HIZ 2'h2
`define ACT_NONE 2'h3

// timing figures in ns and the core clock period
`define CLK_PERIOD_NS 50
`define ADC_DLY_BASE_NS 280
`define TSD_DGL_BASE_NS 250
`define DESAT_DGL_BASE_NS 158
`define SHORT_BLANK_TIME_BASE_NS 100
`define OVERCURRENT_BLANK_TIME_STEP_NS 500
`define GATE_MONITOR_BLANK_TIME_0_NS 500
`define GATE_MONITOR_BLANK_TIME_1_NS 1000
`define GATE_MONITOR_BLANK_TIME_2_NS 2500
`define GATE_MONITOR_BLANK_TIME_3_NS 4000

`endif

// ===== test/gate_cfg_host.sv
`timescale 1ns/100ps
module gate_cfg_host (
  input wire core_clk_i,
  input wire [15:0] rd_data_i,
  output reg wr_en_o = 1'b0,
  output reg [4:0] wr_addr_o = 5'h00,
  output reg [15:0] wr_data_o = 16'h0000,
  output reg [4:0] rd_addr_o = 5'h00
);
  // host writes whenever called; it does not check the device's configuration state
  task wr(input [4:0] a, input [15:0] v);
    begin
      @(negedge core_clk_i);
      wr_en_o = 1'b1;
      wr_addr_o = a;
      wr_data_o = v;
      @(negedge core_clk_i);
      wr_en_o = 1'b0;
      wr_data_o = ~v;
      repeat (2) @(negedge core_clk_i);
    end
  endtask
  task rd(input [4:0] a, output [15:0] v);
    begin
      @(negedge core_clk_i);
      rd_addr_o = a;
      @(negedge core_clk_i);
      v = rd_data_i;
    end
  endtask
endmodule // gate_cfg_host

// ===== test/gate_cfg_properties.sv
`timescale 1ns/100ps
module gate_cfg_properties (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire wr_en_i,
  input wire [4:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  input wire [4:0] rd_addr_i,
  input wire crc_flag_clr_i,
  input wire [15:0] rd_data_o,
  input wire primary_config_crc_flag_o,
  input wire [2:0] odd_bias_on_o,
  input wire soft_turnoff_enable_o,
  input wire two_level_turnoff_enable_o,
  input wire pwm_mute_enable_o,
  input wire [3:0] saturation_threshold_o,
  input wire [1:0] converter_sample_alignment_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire crc_hit = wr_en_i && wr_addr_i == 5'h02 && wr_data_i[10];
  // a second write right behind would move the decode, so only lone writes count
  sequence fs_done; (wr_en_i && wr_addr_i == 5'h02) ##1 !(wr_en_i && wr_addr_i == 5'h02); endsequence
  sequence sat_done; (wr_en_i && wr_addr_i == 5'h04) ##1 !(wr_en_i && wr_addr_i == 5'h04); endsequence
  sequence adc_done; (wr_en_i && wr_addr_i == 5'h06) ##1 !(wr_en_i && wr_addr_i == 5'h06); endsequence
  crc_set_a: assert property (crc_hit |=> primary_config_crc_flag_o)
    else $error("crc flag not set by reserved bit write");
  crc_clear_a: assert property (crc_flag_clr_i && !crc_hit |=> !primary_config_crc_flag_o)
    else $error("crc flag not cleared");
  odd_bias_a: assert property (fs_done |=> odd_bias_on_o ==
    ($past(wr_data_i[5], 2) ? $past(wr_data_i[2:0], 2) : 3'h0))
    else $error("odd bias decode wrong");
  turnoff_excl_a: assert property (!(soft_turnoff_enable_o && two_level_turnoff_enable_o))
    else $error("soft and two level turnoff both on");
  mute_dec_a: assert property (sat_done |=> pwm_mute_enable_o == $past(wr_data_i[0], 2))
    else $error("mute decode wrong");
  sat_thr_a: assert property (sat_done |=> saturation_threshold_o == $past(wr_data_i[14:11], 2))
    else $error("saturation threshold decode wrong");
  adc_align_a: assert property (adc_done |=>
    converter_sample_alignment_o == $past(wr_data_i[6:5], 2))
    else $error("sample alignment decode wrong");
  rd_unmapped_a: assert property ((rd_addr_i < 5'h02 || rd_addr_i > 5'h06) |=> rd_data_o == 16'h0000)
    else $error("unmapped read not zero");
endmodule // gate_cfg_properties
bind gate_driver_protection_config gate_cfg_properties u_gate_cfg_properties (.*);

// ===== test/gate_driver_protection_config_tb.sv
`timescale 1ns/100ps
module gate_driver_protection_config_tb;
  reg core_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg crc_flag_clr_i = 1'b0;
  reg turnoff_active_i = 1'b0;
  reg [8:0] flt = 9'h000;
  wire wr_en_i, primary_config_crc_flag_o, even_input_source_enable_o, clamp_location_select_o;
  wire secondary_undervolt_on_o, secondary_overvolt_on_o, gate_monitor_on_o, miller_clamp_on_o;
  wire short_protect_on_o, overcurrent_protect_on_o, collector_clamp_on_o, saturation_detect_on_o;
  wire switch_thermal_on_o, negative_rail_lockout_on_o, gate_monitor_active_o, pwm_mute_enable_o;
  wire soft_turnoff_enable_o, two_level_turnoff_enable_o, converter_sample_enable_o;
  wire fault_primary_undervolt_i, fault_primary_overvolt_i, fault_pwm_check_i, fault_serial_i;
  wire fault_shoot_through_i, fault_regulator_i, fault_inter_die_comm_i, fault_config_crc_i;
  wire fault_converter_i;
  wire [4:0] wr_addr_i, rd_addr_i;
  wire [15:0] wr_data_i, rd_data_o;
  wire [1:0] gate_action_o, clamp_threshold_o, turnoff_coverage_o, short_threshold_o;
  wire [1:0] secondary_undervolt_threshold_o, converter_sample_alignment_o;
  wire [2:0] odd_bias_on_o, switch_thermal_threshold_o;
  wire [3:0] saturation_threshold_o, overcurrent_threshold_o;
  wire [7:0] switch_thermal_filter_cycles_o, saturation_filter_cycles_o, short_blank_cycles_o;
  wire [7:0] gate_monitor_blank_cycles_o, overcurrent_blank_cycles_o;
  wire [7:0] converter_sample_delay_cycles_o;
  wire [9:0] on_v = {secondary_undervolt_on_o, secondary_overvolt_on_o, gate_monitor_on_o,
    miller_clamp_on_o, short_protect_on_o, overcurrent_protect_on_o, collector_clamp_on_o,
    saturation_detect_on_o, switch_thermal_on_o, negative_rail_lockout_on_o};
  wire [15:0] codes_v = {saturation_threshold_o, short_threshold_o, clamp_threshold_o,
    switch_thermal_threshold_o, secondary_undervolt_threshold_o, converter_sample_alignment_o,
    converter_sample_enable_o};
  wire [15:0] filt_v = {switch_thermal_filter_cycles_o, saturation_filter_cycles_o};
  wire [4:0] toff_v = {soft_turnoff_enable_o, two_level_turnoff_enable_o, turnoff_coverage_o,
    gate_monitor_active_o};
  wire [15:0] adc_v = {secondary_undervolt_threshold_o, converter_sample_alignment_o,
    converter_sample_enable_o, 3'h0, converter_sample_delay_cycles_o};
  localparam [79:0] rst_vals = {16'haa90, 16'h0902, 16'h7741, 16'h0934, 16'h0200};
  localparam [23:0] fs_bit = {4'hf, 4'he, 4'hd, 4'h7, 4'h6, 4'h3};
  localparam [23:0] fs_flt = {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7};
  int fails = 0;
  int n_compared = 0;
  int i;
  reg [15:0] d;
  assign {fault_converter_i, fault_config_crc_i, fault_inter_die_comm_i, fault_regulator_i,
    fault_serial_i, fault_shoot_through_i, fault_pwm_check_i, fault_primary_overvolt_i,
    fault_primary_undervolt_i} = flt;
  gate_driver_protection_config u_gate_driver_protection_config (.*);
  gate_cfg_host u_gate_cfg_host (.core_clk_i(core_clk_i), .rd_data_i(rd_data_o),
    .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i));
  always #25 core_clk_i = ~core_clk_i;
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp) begin
        fails++;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // fault is a level, so holding it two cycles settles any pipeline depth up to two
  task fs(input [4:0] a, input [15:0] v, input int k, input [1:0] e);
    begin
      u_gate_cfg_host.wr(a, v);
      flt = 9'h001 << k;
      repeat (2) @(negedge core_clk_i);
      chk("gate action", {14'h0, gate_action_o}, {14'h0, e});
      flt = 9'h000;
    end
  endtask
  // the whole run needs well under 2000 cycles; ten times that is the limit
  initial begin
    #1000000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    @(negedge core_clk_i);
    for (i = 0; i < 5; i++) begin
      u_gate_cfg_host.rd(i[4:0] + 5'h02, d);
      chk("reset value", d, rst_vals[i*16 +: 16]);
    end
    u_gate_cfg_host.rd(5'h07, d);
    chk("unmapped read", d, 16'h0000);
    chk("reset enables", {6'h0, on_v}, 16'h02ec);
    chk("reset codes", codes_v, 16'he951);
    chk("reset misc", {gate_monitor_blank_cycles_o, gate_action_o, pwm_mute_enable_o, 5'h0}, 16'h14e0);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      u_gate_cfg_host.wr(5'h03, i ? 16'h0000 : 16'hffff);
      chk("enables", {6'h0, on_v}, i ? 16'h03f0 : 16'h000f);
      chk("filters", filt_v, i ? 16'h0504 : 16'h1408);
      chk("gm blank", {gate_monitor_blank_cycles_o, 7'h0, clamp_location_select_o}, i ? 16'h0a00 : 16'h5001);
    end
    $display("test enables done");
    for (i = 0; i < 8; i++) begin
      turnoff_active_i = i[0];
      u_gate_cfg_host.wr(5'h04, {i[1], 11'h0, i[2:0], 1'b0});
      d = {11'h0, i > 0 && i < 4, i > 4, i[1:0], !(i[1] && i[0])};
      chk("turnoff", {11'h0, toff_v}, d);
    end
    chk("mute off", {11'h0, pwm_mute_enable_o, saturation_threshold_o}, 16'h0000);
    $display("test turnoff done");
    u_gate_cfg_host.wr(5'h05, 16'hfcff);
    chk("current codes", {overcurrent_threshold_o, short_threshold_o, switch_thermal_threshold_o, 7'h0}, 16'hff80);
    chk("blanking", {short_blank_cycles_o, overcurrent_blank_cycles_o}, 16'h10c8);
    u_gate_cfg_host.wr(5'h06, 16'hc040);
    chk("adc setup", adc_v, 16'he006);
    $display("test thresholds done");
    u_gate_cfg_host.wr(5'h02, 16'h0025);
    chk("bias", {12'h0, odd_bias_on_o, even_input_source_enable_o}, 16'h000a);
    u_gate_cfg_host.wr(5'h02, 16'h0017);
    chk("bias", {12'h0, odd_bias_on_o, even_input_source_enable_o}, 16'h0001);
    u_gate_cfg_host.wr(5'h02, 16'h0400);
    chk("crc flag", {15'h0, primary_config_crc_flag_o}, 16'h0001);
    chk("crc action", {14'h0, gate_action_o}, 16'h0000);
    u_gate_cfg_host.rd(5'h02, d);
    chk("readback", d, 16'h0400);
    @(negedge core_clk_i) crc_flag_clr_i = 1'b1;
    @(negedge core_clk_i) crc_flag_clr_i = 1'b0;
    @(negedge core_clk_i);
    chk("crc clear", {15'h0, primary_config_crc_flag_o}, 16'h0000);
    $display("test bias crc done");
    for (i = 0; i < 6; i++) begin
      fs(5'h02, 16'h0000, fs_flt[i*4 +: 4], 2'h0);
      fs(5'h02, 16'h0001 << fs_bit[i*4 +: 4], fs_flt[i*4 +: 4], 2'h3);
    end
    for (i = 0; i < 4; i++) begin
      fs(5'h02, {3'h0, i[1:0], 11'h0}, 3, i == 2 ? 2'h3 : i[1:0]);
      fs(5'h02, {6'h0, i[1:0], 8'h00}, 4, i[1] ? 2'h3 : i[1:0]);
      fs(5'h06, {14'h3010, i[1:0]}, 8, i[1:0]);
    end
    $display("test failsafe done");
    stop_test;
  end
endmodule // gate_driver_protection_config_tb
